//--- hdl/prg_region_access_guard.sv
// Region access guard between the core and the on-chip memories, with security alarm.
// Assumes the memory answers a taken read exactly one cycle later, all inputs on core_clk_i.
`timescale 1ns/10ps

// Summary of operation
// - Each access is privileged or user level
// - Eight regions, each with its own rights
// - User accesses checked against region rights
// - Rights violation raises a trap
// - Privileged accesses reach every region
// - User never reaches privileged resources
// - Security error in the run state raises alarm, enters secure state (ignored in the start-up cycle)
// - Regions take predefined values at start-up
module prg_region_access_guard
    import prg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic acc_valid_i,
    input wire prg_acc_t acc_i,
    output logic acc_ready_o,
    output logic rvalid_o,
    output logic [PRG_DATA_W-1:0] rdata_o,
    output logic rerr_o,
    output logic trap_o,
    output logic [1:0] trap_cause_o,
    output logic [PRG_ADDR_W-1:0] trap_addr_o,
    input wire logic cfg_we_i,
    input wire logic cfg_priv_i,
    input wire logic [PRG_IDX_W-1:0] cfg_idx_i,
    input wire prg_region_t cfg_region_i,
    output prg_region_t cfg_rdata_o,
    output logic mem_valid_o,
    output prg_mem_req_t mem_req_o,
    input wire logic mem_ready_i,
    input wire logic mem_rvalid_i,
    input wire logic [PRG_DATA_W-1:0] mem_rdata_i,
    input wire logic [PRG_ALARM_SRCS-1:0] sec_err_i,
    output logic alarm_o,
    output logic [PRG_ALARM_SRCS:0] alarm_src_o,
    output logic secure_reset_o
);

    // ==========================================================
    // State and region table
    prg_state_t state;
    prg_state_t next_state;
    prg_entry_t table_q [PRG_NUM_REGIONS];
    logic blk_rd_q;
    logic fwd_rd_q;

    logic [PRG_NUM_REGIONS-1:0] hit_vec;
    logic [PRG_NUM_REGIONS-1:0] allow_vec;
    logic [PRG_NUM_REGIONS-1:0] par_bad_vec;

    // ==========================================================
    // Region comparators
    genvar gi;
    generate
        for (gi = 0; gi < PRG_NUM_REGIONS; gi++) begin : g_region
            prg_region_match u_match (
                .region_i(table_q[gi].cfg),
                .addr_i(acc_i.addr),
                .write_i(acc_i.write),
                .exec_i(acc_i.exec),
                .hit_o(hit_vec[gi]),
                .allow_o(allow_vec[gi])
            );
            // A flipped bit in a stored entry is treated as tampering
            assign par_bad_vec[gi] = prg_parity(table_q[gi].cfg) != table_q[gi].par;
        end
    endgenerate

    // ==========================================================
    // Region selection: lowest index wins where regions overlap
    logic sel_allow;
    always_comb begin
        sel_allow = 1'b0;
        for (int i = PRG_NUM_REGIONS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                sel_allow = allow_vec[i];
            end
        end
    end

    // ==========================================================
    // Access decision
    wire logic run = (state == PRG_ST_RUN);
    wire logic is_user = !acc_i.priv;
    wire logic in_priv_area = (acc_i.addr >= PRG_PRIV_BASE) && (acc_i.addr <= PRG_PRIV_LIMIT);
    wire logic any_hit = |hit_vec;
    wire logic viol_priv = is_user && in_priv_area;
    wire logic viol_region = is_user && !in_priv_area && !any_hit;
    wire logic viol_rights = is_user && !in_priv_area && any_hit && !sel_allow;
    // Privileged accesses skip the region check entirely
    wire logic violation = viol_priv || viol_region || viol_rights;
    wire logic acc_viol = run && acc_valid_i && violation;
    wire logic cfg_viol = run && cfg_we_i && !cfg_priv_i;
    wire logic cfg_take = run && cfg_we_i && cfg_priv_i;
    wire logic [1:0] acc_cause = viol_priv ? PRG_CAUSE_PRIV_AREA :
                                 viol_region ? PRG_CAUSE_NO_REGION : PRG_CAUSE_RIGHTS;

    // Violations are consumed at once so a stalled memory cannot repeat the trap
    assign acc_ready_o = run && (violation || mem_ready_i);
    assign mem_valid_o = run && acc_valid_i && !violation;
    // Blocked requests never put the address or data on the memory side
    wire prg_mem_req_t fwd_req = prg_mem_req_t'{write: acc_i.write, addr: acc_i.addr,
                                                wdata: acc_i.wdata};
    assign mem_req_o = mem_valid_o ? fwd_req : prg_mem_req_t'('0);
    assign trap_o = acc_viol || cfg_viol;

    wire logic sec_event = (|sec_err_i) || (|par_bad_vec);

    // ==========================================================
    // Mode control
    always_comb begin
        next_state = state;
        case (state)
            PRG_ST_INIT: begin
                // One idle cycle lets the freshly reset table settle before any check
                next_state = PRG_ST_RUN;
            end
            PRG_ST_RUN: begin
                if (sec_event) begin
                    next_state = PRG_ST_SECURE;
                end
            end
            PRG_ST_SECURE: begin
                // Only the chip reset leaves the secure state
                next_state = PRG_ST_SECURE;
            end
            default: begin
                next_state = PRG_ST_SECURE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state <= PRG_ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    assign alarm_o = (state == PRG_ST_SECURE);
    assign secure_reset_o = (state == PRG_ST_SECURE);

    // The first cause is kept; errors seen while secure are not recorded
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            alarm_src_o <= '0;
        end else if (run && sec_event) begin
            alarm_src_o <= {|par_bad_vec, sec_err_i};
        end
    end

    // ==========================================================
    // Region table
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < PRG_NUM_REGIONS; i++) begin
                table_q[i] <= '{cfg: PRG_REGION_RESET, par: prg_parity(PRG_REGION_RESET)};
            end
        end else if (cfg_take) begin
            table_q[cfg_idx_i] <= '{cfg: cfg_region_i, par: prg_parity(cfg_region_i)};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cfg_rdata_o <= PRG_REGION_RESET;
        end else begin
            cfg_rdata_o <= table_q[cfg_idx_i].cfg;
        end
    end

    // ==========================================================
    // Trap record
    // Only the latest trap is kept; software must read it before the next one
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            trap_cause_o <= PRG_CAUSE_NONE;
            trap_addr_o <= '0;
        end else if (acc_viol) begin
            trap_cause_o <= acc_cause;
            trap_addr_o <= acc_i.addr;
        end else if (cfg_viol) begin
            trap_cause_o <= PRG_CAUSE_PRIV_AREA;
            trap_addr_o <= '0;
        end
    end

    // ==========================================================
    // Read return: blocked reads answer zero with an error flag
    // A memory that answers a read late loses its word: no buffer holds it
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            blk_rd_q <= 1'b0;
            fwd_rd_q <= 1'b0;
        end else begin
            blk_rd_q <= acc_viol && !acc_i.write;
            fwd_rd_q <= mem_valid_o && mem_ready_i && !acc_i.write;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= '0;
            rerr_o <= 1'b0;
        end else begin
            rvalid_o <= blk_rd_q || (fwd_rd_q && mem_rvalid_i);
            rdata_o <= (fwd_rd_q && !blk_rd_q) ? mem_rdata_i : '0;
            rerr_o <= blk_rd_q;
        end
    end

endmodule

//--- hdl/prg_pkg.sv
// Shared constants, carriers and the region table layout for the region access guard.
// Assumes a single 40 MHz core clock and synchronous active-low chip reset.
package prg_pkg;

    // ==========================================================
    // Sizes
    localparam int PRG_ADDR_W = 32;
    localparam int PRG_DATA_W = 32;
    localparam int PRG_NUM_REGIONS = 8;
    localparam int PRG_IDX_W = 3;
    localparam int PRG_ALARM_SRCS = 4;

    // ==========================================================
    // Address window owned by the privileged level
    localparam logic [PRG_ADDR_W-1:0] PRG_PRIV_BASE = 32'h0000_0000;
    localparam logic [PRG_ADDR_W-1:0] PRG_PRIV_LIMIT = 32'h0000_3FFF;

    // ==========================================================
    // Trap cause codes
    localparam logic [1:0] PRG_CAUSE_NONE = 2'h0;
    localparam logic [1:0] PRG_CAUSE_PRIV_AREA = 2'h1;
    localparam logic [1:0] PRG_CAUSE_NO_REGION = 2'h2;
    localparam logic [1:0] PRG_CAUSE_RIGHTS = 2'h3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic en;
        logic rd;
        logic wr;
        logic ex;
        logic [PRG_ADDR_W-1:0] base;
        logic [PRG_ADDR_W-1:0] limit;
    } prg_region_t;

    typedef struct packed {
        prg_region_t cfg;
        logic par;
    } prg_entry_t;

    typedef struct packed {
        logic priv;
        logic write;
        logic exec;
        logic [PRG_ADDR_W-1:0] addr;
        logic [PRG_DATA_W-1:0] wdata;
    } prg_acc_t;

    typedef struct packed {
        logic write;
        logic [PRG_ADDR_W-1:0] addr;
        logic [PRG_DATA_W-1:0] wdata;
    } prg_mem_req_t;

    typedef enum logic [1:0] {
        PRG_ST_INIT,
        PRG_ST_RUN,
        PRG_ST_SECURE
    } prg_state_t;

    // ==========================================================
    // Start-up contents of every region: disabled, no user rights
    localparam prg_region_t PRG_REGION_RESET = '{
        en: 1'b0, rd: 1'b0, wr: 1'b0, ex: 1'b0,
        base: 32'h0000_0000, limit: 32'h0000_0000
    };

    // Even parity over one region entry
    function automatic logic prg_parity(input prg_region_t r);
        return ^r;
    endfunction

endpackage

//--- hdl/prg_region_match.sv
// One region comparator: address hit and user-level rights check.
// Assumes base and limit are inclusive and base <= limit when enabled.
`timescale 1ns/10ps
module prg_region_match
    import prg_pkg::*;
(
    input wire prg_region_t region_i,
    input wire logic [PRG_ADDR_W-1:0] addr_i,
    input wire logic write_i,
    input wire logic exec_i,
    output logic hit_o,
    output logic allow_o
);

    // ==========================================================
    // Match and rights
    wire logic in_range = (addr_i >= region_i.base) && (addr_i <= region_i.limit);
    wire logic need_wr = write_i;
    wire logic need_ex = exec_i && !write_i;
    wire logic need_rd = !exec_i && !write_i;

    assign hit_o = region_i.en && in_range;
    assign allow_o = (need_wr && region_i.wr) || (need_ex && region_i.ex)
                     || (need_rd && region_i.rd);

endmodule

//--- verif/prg_guard_monitor.sv
// Checker bound onto the guard top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module prg_guard_monitor
    import prg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic acc_valid_i,
    input wire prg_acc_t acc_i,
    input wire logic acc_ready_o,
    input wire logic rvalid_o,
    input wire logic rerr_o,
    input wire logic trap_o,
    input wire logic cfg_we_i,
    input wire logic cfg_priv_i,
    input wire logic mem_valid_o,
    input wire logic [PRG_ALARM_SRCS-1:0] sec_err_i,
    input wire logic alarm_o
);
    // ====
    // Properties
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic tk = acc_valid_i && acc_ready_o;
    AST_ONE_OUTCOME: assert property (tk && !cfg_we_i |-> trap_o != mem_valid_o)
        else $error("access not trapped or forwarded");
    AST_USER_PRIV: assert property (tk && !acc_i.priv && acc_i.addr <= PRG_PRIV_LIMIT
        |-> trap_o && !mem_valid_o) else $error("user reached privileged area");
    AST_PRIV_PASS: assert property (tk && acc_i.priv |-> mem_valid_o)
        else $error("privileged access blocked");
    AST_USER_CFG: assert property (cfg_we_i && !cfg_priv_i && acc_ready_o |-> trap_o)
        else $error("user region write not trapped");
    AST_BLOCKED_READ: assert property (tk && !mem_valid_o && !acc_i.write
        |-> ##2 rvalid_o && rerr_o) else $error("blocked read not answered");
    AST_ALARM_ENTRY: assert property (|sec_err_i && acc_ready_o |=> alarm_o)
        else $error("no alarm");
    AST_SECURE_HALT: assert property (alarm_o |-> !acc_ready_o && !mem_valid_o ##1 alarm_o)
        else $error("secure state left");
    AST_INIT_WAIT: assert property ($rose(nrst_i) |-> !acc_ready_o)
        else $error("access taken during start-up");
    cover property (tk && trap_o);
    cover property (rvalid_o && !rerr_o);
    cover property ($rose(alarm_o));
endmodule

bind prg_region_access_guard prg_guard_monitor MON (.core_clk_i, .nrst_i, .acc_valid_i,
    .acc_i, .acc_ready_o, .rvalid_o, .rerr_o, .trap_o, .cfg_we_i, .cfg_priv_i, .mem_valid_o,
    .sec_err_i, .alarm_o);

//--- verif/prg_mem_model.sv
// Memory model behind the guard.
// Answers a read one cycle after take; slow mode stalls every other cycle.
`timescale 1ns/10ps
module prg_mem_model
    import prg_pkg::*;
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire prg_mem_req_t req_i,
    output logic ready_o,
    output logic rvalid_o,
    output logic [PRG_DATA_W-1:0] rdata_o
);
    // ====
    // Storage
    logic [PRG_DATA_W-1:0] mem [256];
    logic tick = 1'b0;
    wire logic rd = valid_i && ready_o && !req_i.write;
    assign ready_o = !slow_i || tick;
    initial {rvalid_o, rdata_o} = '0;
    // Idle data is inverted so a stale word cannot pass as an answer
    always @(posedge clk_i) begin
        tick <= !tick;
        rvalid_o <= rd;
        rdata_o <= rd ? mem[req_i.addr[15:8]] : ~rdata_o;
        if (valid_i && ready_o && req_i.write) begin
            mem[req_i.addr[15:8]] <= req_i.wdata;
        end
    end
endmodule

//--- verif/test_privilege_region_guard.sv
// Bench for the region access guard with a memory model behind it.
// Assumes package, guard, checker and model are compiled first.
`timescale 1ns/10ps
module test_privilege_region_guard
    import prg_pkg::*;
;
    // ====
    // Wiring and tasks
    localparam prg_region_t RGN = '{1'b1, 1'b1, 1'b0, 1'b0, 32'h0000_8000, 32'h0000_80FF};
    logic core_clk_i = 0, nrst_i = 0, acc_valid_i = 0, cfg_we_i = 0, cfg_priv_i = 0, slow = 0;
    logic [2:0] cfg_idx_i = 3'h2;
    logic [3:0] sec_err_i = '0;
    prg_acc_t acc_i = '0;
    prg_region_t cfg_region_i = RGN;
    prg_region_t cfg_rdata_o;
    prg_mem_req_t mem_req_o;
    logic acc_ready_o, rvalid_o, rerr_o, trap_o, mem_valid_o, mem_ready_i, mem_rvalid_i;
    logic alarm_o, secure_reset_o;
    logic [1:0] trap_cause_o;
    logic [4:0] alarm_src_o;
    logic [31:0] rdata_o, trap_addr_o, mem_rdata_i;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    always #12.5 core_clk_i = ~core_clk_i;
    prg_region_access_guard DUT (.core_clk_i, .nrst_i, .acc_valid_i, .acc_i, .acc_ready_o,
        .rvalid_o, .rdata_o, .rerr_o, .trap_o, .trap_cause_o, .trap_addr_o, .cfg_we_i,
        .cfg_priv_i, .cfg_idx_i, .cfg_region_i, .cfg_rdata_o, .mem_valid_o, .mem_req_o,
        .mem_ready_i, .mem_rvalid_i, .mem_rdata_i, .sec_err_i, .alarm_o, .alarm_src_o,
        .secure_reset_o);
    prg_mem_model MEM (.clk_i(core_clk_i), .slow_i(slow), .valid_i(mem_valid_o),
        .req_i(mem_req_o), .ready_o(mem_ready_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask
    task automatic tick1;
        @(posedge core_clk_i) #1;
    endtask
    // Trap is judged in the take cycle, cause one cycle on, read answer one after
    task automatic acc(input logic p, w, x, input logic [31:0] a, d, input logic [1:0] c,
        input logic [31:0] rd);
        int n = 0;
        tick1();
        acc_valid_i = 1'b1;
        acc_i = '{p, w, x, a, d};
        #1;
        while (acc_ready_o !== 1'b1 && n < 20) begin
            tick1();
            n++;
        end
        chk("trap", c != 0, trap_o);
        if (c != 0) chk("blocked addr", 0, mem_req_o.addr);
        tick1();
        acc_valid_i = 1'b0;
        if (c != 0) chk("cause", {c, a[29:0]}, {trap_cause_o, trap_addr_o[29:0]});
        if (!w) begin
            tick1();
            chk("answer", {1'b1, c != 0}, {rvalid_o, rerr_o});
            chk("rdata", rd, rdata_o);
        end
    endtask
    task automatic t_start;
        chk("ready in start-up", 0, acc_ready_o);
        acc(0, 0, 0, 32'h0000_8000, 0, 2'h2, 0);
        $display("t_start done");
    endtask
    task automatic t_priv;
        slow = 1'b1;
        acc(1, 1, 0, 32'h0000_0100, 32'hA5A5_0001, 0, 0);
        acc(1, 0, 0, 32'h0000_0100, 0, 0, 32'hA5A5_0001);
        acc(1, 1, 0, 32'h0000_8000, 32'h1234_5678, 0, 0);
        slow = 1'b0;
        $display("t_priv done");
    endtask
    task automatic t_cfg;
        tick1();
        cfg_we_i = 1'b1;
        #1 chk("user cfg trap", 1, trap_o);
        tick1();
        cfg_priv_i = 1'b1;
        chk("user cfg cause", 1, trap_cause_o);
        tick1();
        cfg_we_i = 1'b0;
        tick1();
        chk("region", {RGN[67:64], RGN[27:0]}, {cfg_rdata_o[67:64], cfg_rdata_o[27:0]});
        $display("t_cfg done");
    endtask
    task automatic t_user;
        acc(0, 0, 0, 32'h0000_8000, 0, 0, 32'h1234_5678);
        acc(0, 1, 0, 32'h0000_8000, 32'hDEAD_0000, 2'h3, 0);
        acc(0, 0, 1, 32'h0000_8004, 0, 2'h3, 0);
        acc(0, 0, 0, 32'h0000_8100, 0, 2'h2, 0);
        acc(0, 0, 0, 32'h0000_3FFC, 0, 2'h1, 0);
        acc(0, 0, 0, 32'h0000_8000, 0, 0, 32'h1234_5678);
        $display("t_user done");
    endtask
    task automatic t_alarm;
        tick1();
        sec_err_i = 4'h4;
        tick1();
        sec_err_i = 4'h0;
        acc_valid_i = 1'b1;
        acc_i = '{1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0};
        #1 chk("alarm", 7'h64, {alarm_o, secure_reset_o, alarm_src_o});
        chk("halt", 0, {acc_ready_o, mem_valid_o});
        tick1();
        nrst_i = 1'b0;
        acc_valid_i = 1'b0;
        tick1();
        chk("alarm after reset", 0, {alarm_o, secure_reset_o, alarm_src_o});
        nrst_i = 1'b1;
        acc(0, 0, 0, 32'h0000_8000, 0, 2'h2, 0);
        $display("t_alarm done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        t_start();
        t_priv();
        t_cfg();
        t_user();
        t_alarm();
        report_and_stop();
    end
endmodule
